// ==== mem_decode_pkg.sv ====
// Package: constants, access kinds and carrier structs for the memory space decoder
package mem_decode_pkg;

    // ****************************************
    // Memory sizes and address widths
    // ****************************************
    localparam int RAM_BYTES = 256;
    localparam int RAM_AW = 8;
    localparam int ONCHIP_EXTERNAL_RAM_BYTES = 1024;
    localparam int ONCHIP_EXTERNAL_RAM_AW = 10;

    // ****************************************
    // Program memory map
    // ****************************************
    localparam logic [15:0] CODE_LARGE_TOP = 16'h3FFF;
    localparam logic [15:0] CODE_RESERVED_START = 16'h3E00;
    localparam logic [16:0] CODE_SMALL_BYTES = 17'h0_2000;

    // ****************************************
    // Data memory map
    // ****************************************
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam logic [3:0] BIT_BYTE_BASE_HI = 4'h2;
    localparam int BANK_LSB = 3;
    localparam int BANK_MSB = 4;

    // ****************************************
    // Locally held special registers
    // ****************************************
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] PAGE_CONTROL_ADDR = 8'hAA;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam logic [1:0] PAGE_FIELD_RESET = 2'h0;
    localparam int PAGE_FIELD_LSB = 0;
    localparam int PAGE_FIELD_MSB = 1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        acc_code, acc_direct, acc_indirect, acc_register, acc_bit,
        acc_xdata_ri, acc_xdata_wide, acc_push, acc_pop
    } access_kind_type;

    typedef struct packed {
        access_kind_type kind;
        logic write;
        logic ri_sel;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_op;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_bus_type;

endpackage

// ==== internal_ram.sv ====
// Internal data RAM: 256 bytes, two asynchronous read ports, one write port
`timescale 1ns/1ps
`default_nettype none
module internal_ram
    import mem_decode_pkg::*;
(
    input wire logic clk,
    input wire logic [RAM_AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [RAM_AW-1:0] raddr_b,
    output logic [7:0] rdata_b,
    input wire logic we,
    input wire logic [RAM_AW-1:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [0:RAM_BYTES-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

// ==== onchip_external_ram.sv ====
// On-chip external-space RAM: 1024 bytes, asynchronous read, synchronous write
`timescale 1ns/1ps
`default_nettype none
module onchip_external_ram
    import mem_decode_pkg::*;
(
    input wire logic clk,
    input wire logic [ONCHIP_EXTERNAL_RAM_AW-1:0] addr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [0:ONCHIP_EXTERNAL_RAM_BYTES-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule
`default_nettype wire

// ==== mcu_memory_space_decoder.sv ====
// Memory space decoder: program, internal, bit, stack, external-space and special register routing
`timescale 1ns/1ps
`default_nettype none
module mcu_memory_space_decoder
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire mem_decode_pkg::cpu_req_type req,
    output logic req_ready_q,
    output logic done_q,
    output logic [7:0] rdata_q,
    output logic code_rd_q,
    output logic [15:0] code_addr_q,
    input wire logic [7:0] code_rdata,
    output mem_decode_pkg::sfr_bus_type sfr_q,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] stack_pointer_q,
    output logic [7:0] program_status_word_q,
    output logic [1:0] page_field_q
);
    import mem_decode_pkg::*;

    typedef enum logic [1:0] {st_idle, st_code, st_sfr} state_type;

    state_type state_q, state_d;
    logic req_ready_d, done_d, code_rd_d;
    logic [7:0] rdata_d, stack_pointer_d, program_status_word_d;
    logic [15:0] code_addr_d;
    logic [1:0] page_field_d;
    sfr_bus_type sfr_d;

    logic take;
    logic [1:0] bank;
    logic [7:0] ri_addr, reg_addr, pointer, bit_byte, byte_addr, sp_inc;
    logic bit_in_ram, code_ok;
    logic [7:0] ram_raddr_a, ram_rdata_a, ram_rdata_b, ram_waddr, ram_wdata;
    logic ram_we, onchip_external_ram_we;
    logic [ONCHIP_EXTERNAL_RAM_AW-1:0] onchip_external_ram_addr;
    logic [7:0] onchip_external_ram_rdata;

    // ****************************************
    // Address decoding
    // ****************************************
    always_comb begin
        take = req_valid && req_ready_q;
        bank = program_status_word_q[BANK_MSB:BANK_LSB];
        ri_addr = {3'b000, bank, 2'b00, req.ri_sel};
        reg_addr = {3'b000, bank, req.addr[2:0]};
        pointer = ram_rdata_b;
        sp_inc = stack_pointer_q + 8'h01;
        bit_in_ram = !req.addr[7];
        if (bit_in_ram) begin
            bit_byte = {BIT_BYTE_BASE_HI, req.addr[6:3]};
        end else begin
            bit_byte = {req.addr[7:3], 3'b000};
        end
        if (req.kind == acc_bit) begin
            byte_addr = bit_byte;
        end else begin
            byte_addr = req.addr[7:0];
        end
        if (LARGE_VARIANT) begin
            code_ok = req.addr < CODE_RESERVED_START;
        end else begin
            code_ok = {1'b0, req.addr} < CODE_SMALL_BYTES;
        end
        case (req.kind)
            acc_indirect: ram_raddr_a = pointer;
            acc_register: ram_raddr_a = reg_addr;
            acc_pop: ram_raddr_a = stack_pointer_q;
            acc_push: ram_raddr_a = sp_inc;
            default: ram_raddr_a = byte_addr;
        endcase
        if (req.kind == acc_xdata_ri) begin
            onchip_external_ram_addr = {page_field_q, pointer};
        end else begin
            onchip_external_ram_addr = req.addr[ONCHIP_EXTERNAL_RAM_AW-1:0];
        end
    end

    // ****************************************
    // Access sequencing and local registers
    // ****************************************
    always_comb begin
        logic [7:0] rmw;
        rmw = ram_rdata_a;
        state_d = state_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        code_rd_d = 1'b0;
        code_addr_d = code_addr_q;
        sfr_d = sfr_q;
        sfr_d.rd = 1'b0;
        sfr_d.wr = 1'b0;
        stack_pointer_d = stack_pointer_q;
        program_status_word_d = program_status_word_q;
        page_field_d = page_field_q;
        ram_we = 1'b0;
        ram_waddr = ram_raddr_a;
        ram_wdata = req.wdata;
        onchip_external_ram_we = 1'b0;
        case (state_q)
            st_idle: begin
                if (take) begin
                    done_d = 1'b1;
                    rdata_d = 8'h00;
                    case (req.kind)
                        acc_code: begin
                            if (!req.write && code_ok) begin
                                code_rd_d = 1'b1;
                                code_addr_d = req.addr;
                                done_d = 1'b0;
                                state_d = st_code;
                            end
                        end
                        acc_indirect, acc_register: begin
                            rdata_d = ram_rdata_a;
                            ram_we = req.write;
                        end
                        acc_push: begin
                            ram_we = 1'b1;
                            stack_pointer_d = sp_inc;
                        end
                        acc_pop: begin
                            rdata_d = ram_rdata_a;
                            stack_pointer_d = stack_pointer_q - 8'h01;
                        end
                        acc_xdata_ri, acc_xdata_wide: begin
                            rdata_d = onchip_external_ram_rdata;
                            onchip_external_ram_we = req.write;
                        end
                        default: begin
                            if (!byte_addr[7]) begin
                                rdata_d = ram_rdata_a;
                                if (req.kind == acc_bit) begin
                                    rdata_d = {7'h00, ram_rdata_a[req.addr[2:0]]};
                                    rmw[req.addr[2:0]] = req.wdata[0];
                                    ram_wdata = rmw;
                                end
                                ram_we = req.write;
                            end else if (byte_addr == STATUS_WORD_ADDR) begin
                                rmw = program_status_word_q;
                                rdata_d = rmw;
                                if (req.kind == acc_bit) begin
                                    rdata_d = {7'h00, rmw[req.addr[2:0]]};
                                    rmw[req.addr[2:0]] = req.wdata[0];
                                end else begin
                                    rmw = req.wdata;
                                end
                                if (req.write) begin
                                    program_status_word_d = rmw;
                                end
                            end else if (byte_addr == STACK_POINTER_ADDR &&
                                         req.kind == acc_direct) begin
                                rdata_d = stack_pointer_q;
                                if (req.write) begin
                                    stack_pointer_d = req.wdata;
                                end
                            end else if (byte_addr == PAGE_CONTROL_ADDR &&
                                         req.kind == acc_direct) begin
                                rdata_d = {6'h00, page_field_q};
                                if (req.write) begin
                                    page_field_d = req.wdata[PAGE_FIELD_MSB:PAGE_FIELD_LSB];
                                end
                            end else begin
                                sfr_d.rd = !req.write;
                                sfr_d.wr = req.write;
                                sfr_d.bit_op = (req.kind == acc_bit);
                                sfr_d.bit_sel = req.addr[2:0];
                                sfr_d.addr = byte_addr;
                                sfr_d.wdata = req.wdata;
                                done_d = 1'b0;
                                state_d = st_sfr;
                            end
                        end
                    endcase
                end
            end
            st_code: begin
                rdata_d = code_rdata;
                done_d = 1'b1;
                state_d = st_idle;
            end
            default: begin
                if (sfr_q.bit_op) begin
                    rdata_d = {7'h00, sfr_rdata[sfr_q.bit_sel]};
                end else begin
                    rdata_d = sfr_rdata;
                end
                done_d = 1'b1;
                state_d = st_idle;
            end
        endcase
        req_ready_d = (state_d == st_idle);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= st_idle;
            req_ready_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            code_rd_q <= 1'b0;
            code_addr_q <= 16'h0000;
            sfr_q <= '0;
            stack_pointer_q <= STACK_POINTER_RESET;
            program_status_word_q <= STATUS_WORD_RESET;
            page_field_q <= PAGE_FIELD_RESET;
        end else begin
            state_q <= state_d;
            req_ready_q <= req_ready_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            code_rd_q <= code_rd_d;
            code_addr_q <= code_addr_d;
            sfr_q <= sfr_d;
            stack_pointer_q <= stack_pointer_d;
            program_status_word_q <= program_status_word_d;
            page_field_q <= page_field_d;
        end
    end

    // ****************************************
    // Memories
    // ****************************************
    internal_ram u_internal_ram (
        .clk(clk),
        .raddr_a(ram_raddr_a),
        .rdata_a(ram_rdata_a),
        .raddr_b(ri_addr),
        .rdata_b(ram_rdata_b),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata)
    );

    onchip_external_ram u_onchip_external_ram (
        .clk(clk),
        .addr(onchip_external_ram_addr),
        .rdata(onchip_external_ram_rdata),
        .we(onchip_external_ram_we),
        .wdata(req.wdata)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_sp_reset;
        $rose(reset_n) |-> stack_pointer_q == STACK_POINTER_RESET;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 0x07 after reset");

    property p_push;
        take && req.kind == acc_push |-> ram_we && ram_waddr == stack_pointer_q + 8'h01
            ##1 stack_pointer_q == $past(stack_pointer_q) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push did not pre-increment");

    property p_code_write;
        take && req.kind == acc_code && req.write |=> !code_rd_q && done_q && rdata_q == 8'h00;
    endproperty
    a_code_write: assert property (p_code_write) else $error("code write reached memory");

    property p_code_reserved;
        take && req.kind == acc_code && LARGE_VARIANT && req.addr >= CODE_RESERVED_START
            |=> !code_rd_q && done_q;
    endproperty
    a_code_reserved: assert property (p_code_reserved) else $error("reserved code read");

    property p_indirect_no_sfr;
        take && req.kind == acc_indirect |=> !sfr_q.rd && !sfr_q.wr && done_q;
    endproperty
    a_indirect_no_sfr: assert property (p_indirect_no_sfr) else $error("indirect hit sfr");

    property p_sfr_route;
        take && req.kind == acc_direct && req.addr[7] && req.addr[7:0] != STACK_POINTER_ADDR
            && req.addr[7:0] != STATUS_WORD_ADDR && req.addr[7:0] != PAGE_CONTROL_ADDR
            |=> (sfr_q.rd || sfr_q.wr) && sfr_q.addr == $past(req.addr[7:0]) ##1 done_q;
    endproperty
    a_sfr_route: assert property (p_sfr_route) else $error("direct upper not routed");

    property p_sfr_bit;
        (sfr_q.rd || sfr_q.wr) && sfr_q.bit_op |-> sfr_q.addr[2:0] == 3'b000;
    endproperty
    a_sfr_bit: assert property (p_sfr_bit) else $error("bit access to non-bit sfr");

    property p_bank;
        take && req.kind == acc_register |-> ram_raddr_a[7:5] == 3'b000
            && ram_raddr_a[4:3] == program_status_word_q[BANK_MSB:BANK_LSB];
    endproperty
    a_bank: assert property (p_bank) else $error("register outside active bank");

    property p_page_read;
        take && req.kind == acc_direct && !req.write && req.addr[7:0] == PAGE_CONTROL_ADDR
            |=> rdata_q[7:2] == 6'h00 && rdata_q[1:0] == $past(page_field_q);
    endproperty
    a_page_read: assert property (p_page_read) else $error("page register upper bits");

    property p_wide_alias;
        take && req.kind == acc_xdata_wide |-> onchip_external_ram_addr == req.addr[9:0];
    endproperty
    a_wide_alias: assert property (p_wide_alias) else $error("pointer alias wrong");

    c_push: cover property (take && req.kind == acc_push);
    c_sfr_read: cover property (sfr_q.rd ##1 done_q);
    c_code_read: cover property (code_rd_q ##1 done_q);
    c_xdata_ri: cover property (take && req.kind == acc_xdata_ri && req.write);
endmodule
`default_nettype wire

// ==== mem_far_side_model.sv ====
// Far side model: program memory image and peripheral special register responder
`timescale 1ns/1ps
`default_nettype none
module mem_far_side_model
    import mem_decode_pkg::*;
(
    input wire logic clk,
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    output logic [7:0] code_rdata,
    input wire mem_decode_pkg::sfr_bus_type special_register_space,
    output logic [7:0] sfr_rdata
);
    // ****************************************
    // Peripheral register file
    // ****************************************
    logic [7:0] regs [256];
    logic [7:0] churn;

    initial begin
        churn = 8'h00;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
        end
    end

    // Bit writes are merged here, the block only names the bit
    always @(posedge clk) begin
        churn <= churn + 8'h3B;
        if (special_register_space.wr) begin
            if (special_register_space.bit_op) begin
                regs[special_register_space.addr][special_register_space.bit_sel] <= special_register_space.wdata[0];
            end else begin
                regs[special_register_space.addr] <= special_register_space.wdata;
            end
        end
    end

    // ****************************************
    // Read data, only valid while strobed
    // ****************************************
    always_comb begin
        code_rdata = code_rd ? (code_addr[7:0] ^ code_addr[15:8] ^ 8'hA5) : churn;
        sfr_rdata = special_register_space.rd ? regs[special_register_space.addr] : ~churn;
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Testbench for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mem_decode_pkg::*;
    logic clk;
    logic reset_n;
    logic req_valid;
    cpu_req_type req;
    logic req_ready_q;
    logic done_q;
    logic code_rd_q;
    logic [7:0] rdata_q;
    logic [7:0] code_rdata;
    logic [7:0] sfr_rdata;
    logic [7:0] stack_pointer_q;
    logic [7:0] program_status_word_q;
    logic [15:0] code_addr_q;
    sfr_bus_type sfr_q;
    logic [1:0] page_field_q;
    logic [7:0] q;
    logic [7:0] small_rdata_q;
    int failures = 0;
    int comparisons = 0;

    mcu_memory_space_decoder #(.LARGE_VARIANT(1'b1)) dut (
        .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .req_ready_q(req_ready_q), .done_q(done_q), .rdata_q(rdata_q),
        .code_rd_q(code_rd_q), .code_addr_q(code_addr_q), .code_rdata(code_rdata),
        .sfr_q(sfr_q), .sfr_rdata(sfr_rdata), .stack_pointer_q(stack_pointer_q),
        .program_status_word_q(program_status_word_q), .page_field_q(page_field_q)
    );

    // Small variant runs in step with the large one on the same requests
    mcu_memory_space_decoder #(.LARGE_VARIANT(1'b0)) dut_small (
        .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .req_ready_q(), .done_q(), .rdata_q(small_rdata_q),
        .code_rd_q(), .code_addr_q(), .code_rdata(code_rdata),
        .sfr_q(), .sfr_rdata(sfr_rdata), .stack_pointer_q(),
        .program_status_word_q(), .page_field_q()
    );

    mem_far_side_model far (
        .clk(clk), .code_rd(code_rd_q), .code_addr(code_addr_q), .code_rdata(code_rdata),
        .special_register_space(sfr_q), .sfr_rdata(sfr_rdata)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    function automatic logic [7:0] code_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic access(input access_kind_type k, input logic w, input logic ri,
            input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{kind: k, write: w, ri_sel: ri, addr: a, wdata: d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready_q !== 1'b1 && n < 20);
        req_valid <= 1'b0;
        n = 0;
        #1;
        while (done_q !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done_q !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t no answer to request", $time);
        end
        q = rdata_q;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        check(stack_pointer_q, 8'h07, "stack pointer reset");
        check(program_status_word_q, 8'h00, "status word reset");
        check({6'h00, page_field_q}, 8'h00, "page field reset");
        access(acc_direct, 1'b0, 1'b0, 16'h0081, 8'h00);
        check(q, 8'h07, "stack pointer read");
        $display("test reset done");
    endtask

    task automatic t_stack;
        access(acc_push, 1'b1, 1'b0, 16'h0000, 8'h3C);
        check(stack_pointer_q, 8'h08, "pointer after push");
        access(acc_direct, 1'b0, 1'b0, 16'h0008, 8'h00);
        check(q, 8'h3C, "first push location");
        access(acc_push, 1'b1, 1'b0, 16'h0000, 8'hC3);
        access(acc_pop, 1'b0, 1'b0, 16'h0000, 8'h00);
        check(q, 8'hC3, "pop value");
        check(stack_pointer_q, 8'h08, "pointer after pop");
        access(acc_direct, 1'b1, 1'b0, 16'h0081, 8'hF0);
        access(acc_push, 1'b1, 1'b0, 16'h0000, 8'h77);
        check(stack_pointer_q, 8'hF1, "pointer in upper half");
        access(acc_register, 1'b1, 1'b0, 16'h0000, 8'hF1);
        access(acc_indirect, 1'b0, 1'b0, 16'h0000, 8'h00);
        check(q, 8'h77, "push into upper RAM");
        access(acc_direct, 1'b1, 1'b0, 16'h0081, 8'h07);
        $display("test stack done");
    endtask

    task automatic t_banks;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 8'(i);
            access(acc_direct, 1'b1, 1'b0, 16'h00D0, {v[4:0], 3'b000});
            check(program_status_word_q, {v[4:0], 3'b000}, "bank select");
            access(acc_register, 1'b1, 1'b0, 16'h0002, 8'h50 + v);
            access(acc_direct, 1'b0, 1'b0, {8'h00, v[4:0], 3'b010}, 8'h00);
            check(q, 8'h50 + v, "bank register location");
            access(acc_register, 1'b1, 1'b0, 16'h0001, 8'h60 + v);
            access(acc_direct, 1'b1, 1'b0, {8'h00, 8'h60 + v}, 8'hA0 + v);
            access(acc_indirect, 1'b0, 1'b1, 16'h0000, 8'h00);
            check(q, 8'hA0 + v, "indirect through index one");
        end
        access(acc_direct, 1'b1, 1'b0, 16'h00D0, 8'h00);
        $display("test banks done");
    endtask

    task automatic t_split;
        access(acc_direct, 1'b1, 1'b0, 16'h0090, 8'h11);
        access(acc_register, 1'b1, 1'b0, 16'h0000, 8'h90);
        access(acc_indirect, 1'b1, 1'b0, 16'h0000, 8'h22);
        access(acc_direct, 1'b0, 1'b0, 16'h0090, 8'h00);
        check(q, 8'h11, "direct reaches special register");
        access(acc_indirect, 1'b0, 1'b0, 16'h0000, 8'h00);
        check(q, 8'h22, "indirect reaches upper RAM");
        $display("test split done");
    endtask

    task automatic t_bits;
        access(acc_direct, 1'b1, 1'b0, 16'h0022, 8'h00);
        access(acc_direct, 1'b1, 1'b0, 16'h002F, 8'h00);
        access(acc_bit, 1'b1, 1'b0, 16'h0013, 8'h01);
        access(acc_bit, 1'b1, 1'b0, 16'h007F, 8'h01);
        access(acc_direct, 1'b0, 1'b0, 16'h0022, 8'h00);
        check(q, 8'h08, "bit 0x13 in byte 0x22");
        access(acc_direct, 1'b0, 1'b0, 16'h002F, 8'h00);
        check(q, 8'h80, "bit 0x7F in byte 0x2F");
        access(acc_bit, 1'b0, 1'b0, 16'h0013, 8'h00);
        check(q, 8'h01, "bit read set");
        access(acc_bit, 1'b0, 1'b0, 16'h0012, 8'h00);
        check(q, 8'h00, "bit read clear");
        access(acc_direct, 1'b1, 1'b0, 16'h0088, 8'h00);
        access(acc_bit, 1'b1, 1'b0, 16'h008B, 8'h01);
        access(acc_direct, 1'b0, 1'b0, 16'h0088, 8'h00);
        check(q, 8'h08, "special register bit write");
        access(acc_bit, 1'b0, 1'b0, 16'h008B, 8'h00);
        check(q, 8'h01, "special register bit read");
        $display("test bits done");
    endtask

    task automatic t_code;
        access(acc_code, 1'b0, 1'b0, 16'h1234, 8'h00);
        check(q, code_val(16'h1234), "code byte read");
        access(acc_code, 1'b1, 1'b0, 16'h1234, 8'h00);
        access(acc_code, 1'b0, 1'b0, 16'h1234, 8'h00);
        check(q, code_val(16'h1234), "code after write attempt");
        access(acc_code, 1'b0, 1'b0, 16'h3DFF, 8'h00);
        check(q, code_val(16'h3DFF), "last user code byte");
        check(small_rdata_q, 8'h00, "small variant above 8192");
        access(acc_code, 1'b0, 1'b0, 16'h1FFF, 8'h00);
        check(small_rdata_q, code_val(16'h1FFF), "small variant last byte");
        access(acc_code, 1'b0, 1'b0, 16'h2000, 8'h00);
        check(q, code_val(16'h2000), "large variant past 8192");
        check(small_rdata_q, 8'h00, "small variant first missing byte");
        access(acc_code, 1'b0, 1'b0, 16'h3E00, 8'h00);
        check(q, 8'h00, "reserved code start");
        access(acc_code, 1'b0, 1'b0, 16'h3FFF, 8'h00);
        check(q, 8'h00, "reserved code top");
        access(acc_direct, 1'b1, 1'b0, 16'h0040, 8'h99);
        access(acc_code, 1'b0, 1'b0, 16'h0040, 8'h00);
        check(q, code_val(16'h0040), "code space at shared address");
        access(acc_direct, 1'b0, 1'b0, 16'h0040, 8'h00);
        check(q, 8'h99, "data space at shared address");
        $display("test code done");
    endtask

    task automatic t_onchip_external_ram;
        access(acc_direct, 1'b1, 1'b0, 16'h00AA, 8'hFF);
        check({6'h00, page_field_q}, 8'h03, "page field write");
        access(acc_direct, 1'b0, 1'b0, 16'h00AA, 8'h00);
        check(q, 8'h03, "page control read");
        access(acc_register, 1'b1, 1'b0, 16'h0000, 8'h10);
        access(acc_xdata_ri, 1'b1, 1'b0, 16'h0000, 8'h5E);
        access(acc_xdata_wide, 1'b0, 1'b0, 16'hFF10, 8'h00);
        check(q, 8'h5E, "paged write seen by pointer");
        access(acc_xdata_wide, 1'b1, 1'b0, 16'h7C05, 8'hE7);
        access(acc_direct, 1'b1, 1'b0, 16'h00AA, 8'h00);
        access(acc_register, 1'b1, 1'b0, 16'h0000, 8'h05);
        access(acc_xdata_ri, 1'b0, 1'b0, 16'h0000, 8'h00);
        check(q, 8'hE7, "pointer alias seen on page 0");
        access(acc_direct, 1'b1, 1'b0, 16'h00AA, 8'h01);
        access(acc_xdata_ri, 1'b1, 1'b0, 16'h0000, 8'h1F);
        access(acc_xdata_wide, 1'b0, 1'b0, 16'h0505, 8'h00);
        check(q, 8'h1F, "page 1 write");
        $display("test external RAM done");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever begin
            #50 clk = ~clk;
        end
    end

    initial begin
        repeat (8000) @(posedge clk);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_stack();
        t_banks();
        t_split();
        t_bits();
        t_code();
        t_onchip_external_ram();
        complete_run();
    end
endmodule
`default_nettype wire
